// file: nvs_consts.vh
// Constants for the nonvolatile static memory host controller.
// Assumes a 20 MHz clock and a memory with a 15-bit address and 8-bit data.
`ifndef NVS_CONSTS_VH
`define NVS_CONSTS_VH

`define NVS_CLK_PERIOD_NS 50

// Host command codes
`define NVS_OP_READ 3'h0
`define NVS_OP_WRITE 3'h1
`define NVS_OP_SW_SAVE 3'h2
`define NVS_OP_SW_RESTORE 3'h3
`define NVS_OP_AUTO_OFF 3'h4
`define NVS_OP_AUTO_ON 3'h5
`define NVS_OP_HW_SAVE 3'h6

// Software sequence addresses
`define NVS_SEQ_ADDR1 15'h0E38
`define NVS_SEQ_ADDR2 15'h31C7
`define NVS_SEQ_ADDR3 15'h03E0
`define NVS_SEQ_ADDR4 15'h3C1F
`define NVS_SEQ_ADDR5 15'h303F
`define NVS_SEQ_SAVE 15'h0FC0
`define NVS_SEQ_RESTORE 15'h0C63
`define NVS_SEQ_AUTO_OFF 15'h0B45
`define NVS_SEQ_AUTO_ON 15'h0B46
`define NVS_SEQ_LAST 3'h5
`define NVS_MODE_ADDR_MASK 15'h3FFF

`endif

// file: nvs_sync.v
// Two-flop synchroniser for pin inputs.
// Assumes inputs asynchronous to clk_in; output is delayed two edges.
`timescale 1ns/10ps
module nvs_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input wire clk_in,         // Clock
	input wire rst_in,         // Synchronous reset, active high
	input wire [W-1:0] d_in,   // Asynchronous input
	output wire [W-1:0] q_out  // Synchronised output
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge clk_in) begin
		if (rst_in) begin
			meta_q <= INIT;
			sync_q <= INIT;
		end else begin
			meta_q <= d_in;
			sync_q <= meta_q;
		end
	end

	assign q_out = sync_q;
endmodule

// file: nvs_host_ctrl.v
// Host controller that drives a nonvolatile static memory over its asynchronous pins.
// Assumes pins are asynchronous; the memory has an open-drain busy line with pull-up.
`timescale 1ns/10ps
`include "nvs_consts.vh"
module nvs_host_ctrl #(
	parameter TMR_W = 24,
	parameter SAVE_DELAY_NS = 1000,
	parameter POST_BUSY_NS = 100,
	parameter POWERUP_RESTORE_NS = 20000000,
	parameter SAVE_CYCLE_NS = 8000000,
	parameter RESTORE_CYCLE_NS = 200000,
	parameter READ_NS = 100,
	parameter WRITE_NS = 100,
	parameter GAP_NS = 50
) (
	input wire REF_CLK_IN,            // Clock, 20 MHz
	input wire RESET_IN,              // Synchronous reset, active high
	input wire CMD_VALID_IN,          // Command request
	input wire [2:0] CMD_OP_IN,       // Command code
	input wire [14:0] CMD_ADDR_IN,    // Memory address
	input wire [7:0] CMD_WDATA_IN,    // Write data
	output wire CMD_READY_OUT,        // Command accepted when high with valid
	output reg RSP_VALID_OUT,         // Command done, one-cycle pulse
	output reg [7:0] RSP_RDATA_OUT,   // Read data
	output wire BUSY_OUT,             // Controller not idle
	input wire VCC_LOW_IN,            // Supply below switch threshold, active high
	output reg MEM_CE_N_OUT,          // Chip enable, active low
	output reg MEM_WE_N_OUT,          // Write enable, active low
	output reg MEM_OE_N_OUT,          // Output enable, active low
	output reg [14:0] MEM_ADDR_OUT,   // Address pins
	input wire [7:0] MEM_DQ_IN,       // Data pins in
	output reg [7:0] MEM_DQ_OUT,      // Data pins out
	output reg MEM_DQ_OE_N_OUT,       // Data drive enable, active low
	input wire SAVE_BUSY_LINE_N_IN,   // Busy line level
	output wire SAVE_BUSY_LINE_N_OUT, // Busy line drive value, always low
	output reg SAVE_BUSY_LINE_OE_N_OUT // Busy line pull enable, active low
);
	function [TMR_W-1:0] cyc_up;
		input integer ns;
		integer c;
		begin
			c = (ns + `NVS_CLK_PERIOD_NS - 1) / `NVS_CLK_PERIOD_NS;
			if (c < 1) begin
				c = 1;
			end
			cyc_up = c[TMR_W-1:0];
		end
	endfunction

	// Address of each sequence step; only the low fourteen bits are driven
	function [14:0] seq_addr;
		input [2:0] idx;
		input [2:0] op;
		reg [14:0] a;
		begin
			a = `NVS_SEQ_ADDR1;
			case (idx)
				3'h0: a = `NVS_SEQ_ADDR1;
				3'h1: a = `NVS_SEQ_ADDR2;
				3'h2: a = `NVS_SEQ_ADDR3;
				3'h3: a = `NVS_SEQ_ADDR4;
				3'h4: a = `NVS_SEQ_ADDR5;
				default: begin
					case (op)
						`NVS_OP_SW_RESTORE: a = `NVS_SEQ_RESTORE;
						`NVS_OP_AUTO_OFF: a = `NVS_SEQ_AUTO_OFF;
						`NVS_OP_AUTO_ON: a = `NVS_SEQ_AUTO_ON;
						default: a = `NVS_SEQ_SAVE;
					endcase
				end
			endcase
			seq_addr = a & `NVS_MODE_ADDR_MASK;
		end
	endfunction

	localparam [TMR_W-1:0] TMR_ZERO = {TMR_W{1'b0}};
	localparam [TMR_W-1:0] TMR_ONE = {{(TMR_W-1){1'b0}}, 1'b1};
	// Read strobe is stretched by the two synchroniser stages
	localparam [TMR_W-1:0] LD_SAVE_DELAY = cyc_up(SAVE_DELAY_NS) + TMR_ONE;
	localparam [TMR_W-1:0] LD_POST_BUSY = cyc_up(POST_BUSY_NS) - TMR_ONE;
	localparam [TMR_W-1:0] LD_POWERUP = cyc_up(POWERUP_RESTORE_NS) - TMR_ONE;
	localparam [TMR_W-1:0] LD_SAVE_CYC = cyc_up(SAVE_CYCLE_NS) - TMR_ONE;
	localparam [TMR_W-1:0] LD_RESTORE = cyc_up(RESTORE_CYCLE_NS) - TMR_ONE;
	localparam [TMR_W-1:0] LD_READ = cyc_up(READ_NS) + TMR_ONE;
	localparam [TMR_W-1:0] LD_WRITE = cyc_up(WRITE_NS) - TMR_ONE;
	localparam [TMR_W-1:0] LD_GAP = cyc_up(GAP_NS) - TMR_ONE;

	localparam [3:0] ST_INIT = 4'h0;
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_RD = 4'h2;
	localparam [3:0] ST_WR = 4'h3;
	localparam [3:0] ST_GAP = 4'h4;
	localparam [3:0] ST_SEQ_RD = 4'h5;
	localparam [3:0] ST_SEQ_GAP = 4'h6;
	localparam [3:0] ST_HW_PULL = 4'h7;
	localparam [3:0] ST_NV_WAIT = 4'h8;
	localparam [3:0] ST_WAIT_HI = 4'h9;
	localparam [3:0] ST_RECOV = 4'hA;

	wire busy_n_s;
	wire vcc_low_s;
	wire [7:0] dq_s;

	nvs_sync #(.W(10), .INIT(10'h001)) u_sync (
		.clk_in(REF_CLK_IN),
		.rst_in(RESET_IN),
		.d_in({MEM_DQ_IN, VCC_LOW_IN, SAVE_BUSY_LINE_N_IN}),
		.q_out({dq_s, vcc_low_s, busy_n_s})
	);

	reg [3:0] state_q, state_d;
	reg [TMR_W-1:0] tmr_q, tmr_d;
	reg [2:0] op_q, op_d;
	reg [2:0] seq_idx_q, seq_idx_d;
	reg chain_save_q, chain_save_d;
	reg [14:0] addr_d;
	reg [7:0] wdata_d;
	reg ce_n_d, we_n_d, oe_n_d, dq_oe_n_d, line_oe_n_d;
	reg rsp_valid_d;
	reg [7:0] rdata_d;

	wire tmr_done = (tmr_q == TMR_ZERO);

	// Line low or supply low blocks every new access
	assign CMD_READY_OUT = (state_q == ST_IDLE) && busy_n_s && !vcc_low_s;
	assign BUSY_OUT = (state_q != ST_IDLE);
	assign SAVE_BUSY_LINE_N_OUT = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	always @* begin
		state_d = state_q;
		tmr_d = tmr_done ? TMR_ZERO : tmr_q - TMR_ONE;
		op_d = op_q;
		seq_idx_d = seq_idx_q;
		chain_save_d = chain_save_q;
		addr_d = MEM_ADDR_OUT;
		wdata_d = MEM_DQ_OUT;
		ce_n_d = 1'b1;
		we_n_d = 1'b1;
		oe_n_d = 1'b1;
		dq_oe_n_d = 1'b1;
		line_oe_n_d = 1'b1;
		rsp_valid_d = 1'b0;
		rdata_d = RSP_RDATA_OUT;
		case (state_q)
			ST_INIT: begin
				// Restore runs only once supply is back, so the count restarts while low
				if (vcc_low_s) begin
					tmr_d = LD_POWERUP;
				end else if (tmr_done) begin
					state_d = ST_WAIT_HI;
				end
			end
			ST_IDLE: begin
				if (vcc_low_s) begin
					state_d = ST_INIT;
					tmr_d = LD_POWERUP;
				end else if (CMD_VALID_IN && CMD_READY_OUT) begin
					op_d = CMD_OP_IN;
					addr_d = CMD_ADDR_IN;
					wdata_d = CMD_WDATA_IN;
					chain_save_d = 1'b0;
					case (CMD_OP_IN)
						`NVS_OP_READ: begin
							state_d = ST_RD;
							tmr_d = LD_READ;
							ce_n_d = 1'b0;
							oe_n_d = 1'b0;
						end
						`NVS_OP_WRITE: begin
							state_d = ST_WR;
							tmr_d = LD_WRITE;
							ce_n_d = 1'b0;
							we_n_d = 1'b0;
							dq_oe_n_d = 1'b0;
						end
						`NVS_OP_HW_SAVE: begin
							state_d = ST_HW_PULL;
							tmr_d = LD_SAVE_DELAY;
							line_oe_n_d = 1'b0;
						end
						default: begin
							state_d = ST_SEQ_RD;
							seq_idx_d = 3'h0;
							addr_d = seq_addr(3'h0, CMD_OP_IN);
							tmr_d = LD_READ;
							ce_n_d = 1'b0;
							oe_n_d = 1'b0;
						end
					endcase
				end
			end
			ST_RD: begin
				ce_n_d = 1'b0;
				oe_n_d = 1'b0;
				if (tmr_done) begin
					rdata_d = dq_s;
					ce_n_d = 1'b1;
					oe_n_d = 1'b1;
					state_d = ST_GAP;
					tmr_d = LD_GAP;
				end
			end
			ST_WR: begin
				ce_n_d = 1'b0;
				we_n_d = 1'b0;
				dq_oe_n_d = 1'b0;
				if (tmr_done) begin
					// Data stays driven two cycles past the write-enable rise
					we_n_d = 1'b1;
					ce_n_d = 1'b1;
					state_d = ST_GAP;
					tmr_d = LD_GAP;
				end
			end
			ST_GAP: begin
				dq_oe_n_d = (op_q == `NVS_OP_WRITE) && (tmr_q == LD_GAP) ? 1'b0 : 1'b1;
				if (tmr_done) begin
					state_d = ST_IDLE;
					rsp_valid_d = 1'b1;
				end
			end
			ST_SEQ_RD: begin
				// Write-enable never falls inside a sequence
				ce_n_d = 1'b0;
				oe_n_d = 1'b0;
				if (tmr_done) begin
					ce_n_d = 1'b1;
					oe_n_d = 1'b1;
					state_d = ST_SEQ_GAP;
					tmr_d = LD_GAP;
				end
			end
			ST_SEQ_GAP: begin
				if (tmr_done) begin
					if (seq_idx_q == `NVS_SEQ_LAST) begin
						case (op_q)
							`NVS_OP_SW_SAVE: begin
								state_d = ST_NV_WAIT;
								tmr_d = LD_SAVE_CYC;
							end
							`NVS_OP_SW_RESTORE: begin
								state_d = ST_NV_WAIT;
								tmr_d = LD_RESTORE;
							end
							default: begin
								// Setting change is made persistent by a save
								state_d = ST_SEQ_RD;
								op_d = `NVS_OP_SW_SAVE;
								chain_save_d = 1'b1;
								seq_idx_d = 3'h0;
								addr_d = seq_addr(3'h0, `NVS_OP_SW_SAVE);
								tmr_d = LD_READ;
								ce_n_d = 1'b0;
								oe_n_d = 1'b0;
							end
						endcase
					end else begin
						// Next read follows with no other access between
						state_d = ST_SEQ_RD;
						seq_idx_d = seq_idx_q + 3'h1;
						addr_d = seq_addr(seq_idx_q + 3'h1, op_q);
						tmr_d = LD_READ;
						ce_n_d = 1'b0;
						oe_n_d = 1'b0;
					end
				end
			end
			ST_HW_PULL: begin
				line_oe_n_d = 1'b0;
				if (tmr_done) begin
					// Release; the device holds the line if a save runs
					line_oe_n_d = 1'b1;
					state_d = ST_WAIT_HI;
				end
			end
			ST_NV_WAIT: begin
				if (tmr_done) begin
					state_d = ST_WAIT_HI;
				end
			end
			ST_WAIT_HI: begin
				if (busy_n_s) begin
					state_d = ST_RECOV;
					tmr_d = LD_POST_BUSY;
				end
			end
			ST_RECOV: begin
				if (tmr_done) begin
					state_d = ST_IDLE;
					rsp_valid_d = (op_q != `NVS_OP_READ) || chain_save_q;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge REF_CLK_IN) begin
		if (RESET_IN) begin
			state_q <= ST_INIT;
			tmr_q <= LD_POWERUP;
			op_q <= `NVS_OP_READ;
			seq_idx_q <= 3'h0;
			chain_save_q <= 1'b0;
			MEM_CE_N_OUT <= 1'b1;
			MEM_WE_N_OUT <= 1'b1;
			MEM_OE_N_OUT <= 1'b1;
			MEM_ADDR_OUT <= 15'h0000;
			MEM_DQ_OUT <= 8'h00;
			MEM_DQ_OE_N_OUT <= 1'b1;
			SAVE_BUSY_LINE_OE_N_OUT <= 1'b1;
			RSP_VALID_OUT <= 1'b0;
			RSP_RDATA_OUT <= 8'h00;
		end else begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			op_q <= op_d;
			seq_idx_q <= seq_idx_d;
			chain_save_q <= chain_save_d;
			MEM_CE_N_OUT <= ce_n_d;
			MEM_WE_N_OUT <= we_n_d;
			MEM_OE_N_OUT <= oe_n_d;
			MEM_ADDR_OUT <= addr_d;
			MEM_DQ_OUT <= wdata_d;
			MEM_DQ_OE_N_OUT <= dq_oe_n_d;
			SAVE_BUSY_LINE_OE_N_OUT <= line_oe_n_d;
			RSP_VALID_OUT <= rsp_valid_d;
			RSP_RDATA_OUT <= rdata_d;
		end
	end
endmodule

// file: nvs_ctrl_chk.sv
// Port checker for the memory host controller.
// Assumes it is bound to nvs_host_ctrl and that plain accesses avoid the sequence addresses.
`timescale 1ns/10ps
`include "nvs_consts.vh"
module nvs_ctrl_chk (
	input wire REF_CLK_IN, // Clock
	input wire RESET_IN, // Reset
	input wire RSP_VALID_OUT, // Done pulse
	input wire MEM_CE_N_OUT, // Chip enable
	input wire MEM_WE_N_OUT, // Write enable
	input wire MEM_OE_N_OUT, // Output enable
	input wire [14:0] MEM_ADDR_OUT, // Address
	input wire SAVE_BUSY_LINE_N_IN, // Busy line level
	input wire SAVE_BUSY_LINE_OE_N_OUT // Busy line pull
);
// Address of the previous access, for sequence order
reg ce_q;
reg [14:0] prev_q;
wire ce_fall = ce_q & ~MEM_CE_N_OUT;
wire last_hit = MEM_ADDR_OUT == `NVS_SEQ_SAVE || MEM_ADDR_OUT == `NVS_SEQ_RESTORE ||
	MEM_ADDR_OUT == `NVS_SEQ_AUTO_OFF || MEM_ADDR_OUT == `NVS_SEQ_AUTO_ON;
always @(posedge REF_CLK_IN) begin
	ce_q <= RESET_IN | MEM_CE_N_OUT;
	if (ce_fall)
		prev_q <= MEM_ADDR_OUT;
end
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge REF_CLK_IN); endclocking
default disable iff (RESET_IN);
seq_second_a: assert property (
	ce_fall && MEM_ADDR_OUT == `NVS_SEQ_ADDR2 |-> prev_q == `NVS_SEQ_ADDR1)
	else $error("second sequence read not preceded by first");
seq_last_a: assert property (
	ce_fall && last_hit |-> prev_q == `NVS_SEQ_ADDR5)
	else $error("sixth sequence read not preceded by fifth");
read_only_a: assert property (
	!MEM_OE_N_OUT |-> MEM_WE_N_OUT && !MEM_CE_N_OUT)
	else $error("output enable without a clean read");
auto_save_a: assert property (
	ce_fall && (prev_q == `NVS_SEQ_AUTO_OFF || prev_q == `NVS_SEQ_AUTO_ON)
	|-> MEM_ADDR_OUT == `NVS_SEQ_ADDR1)
	else $error("setting change not followed by a save sequence");
pull_bound_a: assert property (
	$fell(SAVE_BUSY_LINE_OE_N_OUT) |-> ##[1:64] SAVE_BUSY_LINE_OE_N_OUT)
	else $error("busy line not released");
pull_quiet_a: assert property (
	!SAVE_BUSY_LINE_OE_N_OUT |-> MEM_CE_N_OUT)
	else $error("access while pulling busy line");
recov_block_a: assert property (
	$rose(SAVE_BUSY_LINE_N_IN) |-> MEM_CE_N_OUT [*4])
	else $error("access too soon after busy line rose");
rsp_pulse_a: assert property (RSP_VALID_OUT |=> !RSP_VALID_OUT)
	else $error("done pulse longer than one cycle");
cover property (ce_fall && last_hit);
cover property ($fell(SAVE_BUSY_LINE_OE_N_OUT));
cover property (RSP_VALID_OUT);
endmodule

// file: nvs_dev_model.sv
// Behavioural model of the nonvolatile memory behind the controller.
// Assumes the bench resolves busy line and data bus; times are counted in clk_in cycles.
`timescale 1ns/10ps
`include "nvs_consts.vh"
module nvs_dev_model #(
	parameter PU = 30,
	parameter SV = 30,
	parameter RC = 15,
	parameter DL = 5,
	parameter REC = 2
) (
	input wire clk_in, // Model time base
	input wire vcc_low_in, // Supply below threshold
	input wire ce_n_in, // Chip enable
	input wire we_n_in, // Write enable
	input wire oe_n_in, // Output enable
	input wire [14:0] addr_in, // Address
	input wire [7:0] dq_in, // Data bus level
	input wire line_n_in, // Busy line level
	output reg pull_out, // Pulls busy line low
	output wire [7:0] dq_out // Read data, else changing junk
);
reg [7:0] mem [0:32767];
reg [7:0] nv [0:32767];
reg dirty, auto_en, pend, is_save, ce_q, pull;
reg [7:0] last;
integer cnt, hcnt, rec, step, i;
wire [14:0] ma = addr_in & `NVS_MODE_ADDR_MASK;
wire rd_ok = !ce_n_in && !oe_n_in && we_n_in && !pull_out && rec == 0;
assign dq_out = rd_ok ? mem[addr_in] : ~last;
initial begin
	for (i = 0; i < 32768; i = i + 1) begin
		mem[i] = 8'h00;
		nv[i] = 8'h00;
	end
	{dirty, pull, is_save, last, cnt, hcnt, rec, step} = 0;
	{auto_en, pend, ce_q} = 3'b111;
end
function [14:0] seqa(input integer s);
	case (s)
		0: seqa = `NVS_SEQ_ADDR1;
		1: seqa = `NVS_SEQ_ADDR2;
		2: seqa = `NVS_SEQ_ADDR3;
		3: seqa = `NVS_SEQ_ADDR4;
		default: seqa = `NVS_SEQ_ADDR5;
	endcase
endfunction
task start(input sv, input integer n);
	begin
		pull = 1'b1;
		is_save = sv;
		cnt = n;
	end
endtask
////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_in) begin
	// Busy pull leaves on the edge, so the controller never races it
	pull_out <= pull;
	ce_q <= ce_n_in;
	last <= dq_out;
	if (vcc_low_in) begin
		if (!pend && auto_en && dirty)
			for (i = 0; i < 32768; i = i + 1) nv[i] = mem[i];
		pend = 1'b1;
		pull = 1'b1;
		cnt = 0;
		step = 0;
	end else if (pend) begin
		pend = 1'b0;
		start(1'b0, PU);
	end else if (cnt > 0) begin
		cnt = cnt - 1;
		if (cnt == 0) begin
			for (i = 0; i < 32768; i = i + 1) begin
				if (is_save) nv[i] = mem[i];
				else mem[i] = nv[i];
			end
			{dirty, pull} = 2'b00;
			rec = REC;
		end
	end else if (rec > 0) begin
		rec = rec - 1;
	end else if (!line_n_in) begin
		hcnt = hcnt + 1;
		if (hcnt == DL && dirty) start(1'b1, SV);
	end else begin
		hcnt = 0;
		if (!ce_n_in && !we_n_in) begin
			mem[addr_in] = dq_in;
			dirty = 1'b1;
			step = 0;
		end else if (ce_q && !ce_n_in && !oe_n_in) begin
			if (step == 5) begin
				step = 0;
				if (ma == `NVS_SEQ_SAVE) start(1'b1, SV);
				else if (ma == `NVS_SEQ_RESTORE) start(1'b0, RC);
				else if (ma == `NVS_SEQ_AUTO_OFF) auto_en = 1'b0;
				else if (ma == `NVS_SEQ_AUTO_ON) auto_en = 1'b1;
			end else
				step = (ma == seqa(step)) ? step + 1 : (ma == `NVS_SEQ_ADDR1);
		end
	end
end
endmodule

// file: nvs_tb.sv
// Self-checking bench for the memory host controller with a memory model.
// Assumes shortened power-up, save and restore times so the run stays short.
`timescale 1ns/10ps
`include "nvs_consts.vh"
module testbench;
reg clk, rst, cmd_valid, vcc_low;
reg [2:0] cmd_op;
reg [14:0] cmd_addr;
reg [7:0] cmd_wdata;
wire ready, rsp_valid, ce_n, we_n, oe_n, dq_oe_n, line_oe_n, line_drv, dev_pull, busy;
wire [7:0] rdata, dq_h, dq_d;
wire [14:0] addr;
wire line = (line_oe_n ? 1'b1 : line_drv) & ~dev_pull;
wire [7:0] dq_bus = dq_oe_n ? dq_d : dq_h;
integer fail_count, checks;
nvs_host_ctrl #(.POWERUP_RESTORE_NS(2000), .SAVE_CYCLE_NS(2000), .RESTORE_CYCLE_NS(1000)) uut (
	.REF_CLK_IN(clk), .RESET_IN(rst), .CMD_VALID_IN(cmd_valid), .CMD_OP_IN(cmd_op),
	.CMD_ADDR_IN(cmd_addr), .CMD_WDATA_IN(cmd_wdata), .CMD_READY_OUT(ready),
	.RSP_VALID_OUT(rsp_valid), .RSP_RDATA_OUT(rdata), .BUSY_OUT(busy), .VCC_LOW_IN(vcc_low),
	.MEM_CE_N_OUT(ce_n), .MEM_WE_N_OUT(we_n), .MEM_OE_N_OUT(oe_n), .MEM_ADDR_OUT(addr),
	.MEM_DQ_IN(dq_bus), .MEM_DQ_OUT(dq_h), .MEM_DQ_OE_N_OUT(dq_oe_n),
	.SAVE_BUSY_LINE_N_IN(line), .SAVE_BUSY_LINE_N_OUT(line_drv),
	.SAVE_BUSY_LINE_OE_N_OUT(line_oe_n));
nvs_dev_model dev (.clk_in(clk), .vcc_low_in(vcc_low), .ce_n_in(ce_n), .we_n_in(we_n),
	.oe_n_in(oe_n), .addr_in(addr), .dq_in(dq_bus), .line_n_in(line), .pull_out(dev_pull),
	.dq_out(dq_d));
initial begin
	clk = 1'b0;
	forever #25 clk = ~clk;
end
////////////////////////////////////////////////////////////////////////////////
task check(input string what, input [7:0] seen, input [7:0] exp);
	begin
		checks = checks + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	end
endtask
task final_report;
	begin
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
endtask
// One command: hold valid until taken, then wait for the done pulse
task cmd(input [2:0] op, input [14:0] a, input [7:0] d);
	integer n;
	begin
		n = 0;
		@(posedge clk);
		cmd_op <= op;
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_valid <= 1'b1;
		@(negedge clk);
		while (ready !== 1'b1 && n < 4000) begin
			n = n + 1;
			@(negedge clk);
		end
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(negedge clk);
		while (rsp_valid !== 1'b1 && n < 4000) begin
			n = n + 1;
			@(negedge clk);
		end
		if (n >= 4000) begin
			fail_count = fail_count + 1;
			final_report;
		end
	end
endtask
task rd(input [14:0] a, input [7:0] exp);
	begin
		cmd(`NVS_OP_READ, a, 8'h00);
		check("read data", rdata, exp);
	end
endtask
task power_dip;
	begin
		@(posedge clk);
		vcc_low <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk);
		check("ready in low supply", {7'h00, ready}, 8'h00);
		check("busy in low supply", {7'h00, busy}, 8'h01);
		@(posedge clk);
		vcc_low <= 1'b0;
	end
endtask
////////////////////////////////////////////////////////////////////////////////
task t_plain;
	begin
		rd(15'h0123, 8'h00);
		cmd(`NVS_OP_WRITE, 15'h0010, 8'h5A);
		cmd(`NVS_OP_WRITE, 15'h4010, 8'hC3);
		rd(15'h0010, 8'h5A);
		rd(15'h4010, 8'hC3);
	end
endtask
task t_sw;
	begin
		cmd(`NVS_OP_SW_SAVE, 15'h0000, 8'h00);
		cmd(`NVS_OP_WRITE, 15'h0010, 8'hA5);
		cmd(`NVS_OP_SW_RESTORE, 15'h0000, 8'h00);
		rd(15'h0010, 8'h5A);
	end
endtask
task t_hw;
	begin
		cmd(`NVS_OP_WRITE, 15'h0020, 8'h11);
		cmd(`NVS_OP_HW_SAVE, 15'h0000, 8'h00);
		cmd(`NVS_OP_WRITE, 15'h0020, 8'h22);
		cmd(`NVS_OP_SW_RESTORE, 15'h0000, 8'h00);
		rd(15'h0020, 8'h11);
		cmd(`NVS_OP_HW_SAVE, 15'h0000, 8'h00);
		rd(15'h0020, 8'h11);
	end
endtask
task t_auto;
	begin
		cmd(`NVS_OP_WRITE, 15'h0030, 8'h77);
		cmd(`NVS_OP_AUTO_OFF, 15'h0000, 8'h00);
		cmd(`NVS_OP_WRITE, 15'h0030, 8'h88);
		power_dip;
		rd(15'h0030, 8'h77);
		cmd(`NVS_OP_AUTO_ON, 15'h0000, 8'h00);
		cmd(`NVS_OP_WRITE, 15'h0030, 8'h99);
		power_dip;
		rd(15'h0030, 8'h99);
	end
endtask
initial begin
	{rst, cmd_valid, vcc_low, cmd_op, cmd_addr, cmd_wdata} = 1'b1 << 28;
	fail_count = 0;
	checks = 0;
	repeat (20) @(posedge clk);
	rst <= 1'b0;
	t_plain;
	t_sw;
	t_hw;
	t_auto;
	final_report;
end
endmodule
bind nvs_host_ctrl nvs_ctrl_chk chk (.REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN),
	.RSP_VALID_OUT(RSP_VALID_OUT), .MEM_CE_N_OUT(MEM_CE_N_OUT), .MEM_WE_N_OUT(MEM_WE_N_OUT),
	.MEM_OE_N_OUT(MEM_OE_N_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT),
	.SAVE_BUSY_LINE_N_IN(SAVE_BUSY_LINE_N_IN),
	.SAVE_BUSY_LINE_OE_N_OUT(SAVE_BUSY_LINE_OE_N_OUT));
